// ===== src/tci_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef TCI_DEFS_SVH
`define TCI_DEFS_SVH
`define OFS_PEND_LO 4'h0
`define OFS_PEND_HI 4'h1
`define OFS_IEN_LO 4'h2
`define OFS_IEN_HI 4'h3
`define OFS_DIEN_LO 4'h4
`define OFS_DIEN_HI 4'h5
`define OFS_STATUS 4'h6
`define OFS_CTRL 4'h7
`define OFS_EVT 4'h8
`define OFS_EVT_MASK 4'h9
`define OFS_VEC_BASE 4'hA
`define CTRL_GIM 0
`define CTRL_DEM 1
`define CTRL_EMU 2
`define EVT_ACK 0
`define EVT_RET 1
`define RST_CTRL 3'h3
`define RST_VEC_BASE 16'h0100
`define DRAIN_CYCLES 2'h2
`endif

// ===== src/tci_pkg.sv
// Types shared by the time-critical interrupt flow
package tci_pkg;
   typedef enum logic [2:0] {IDLE, DRAIN, BRANCH, SERVICE, RESTORE} flow_e;
   // Mode bits forced on entry and restored on return
   typedef struct packed {
      logic emuRegAccessEnable;
      logic debugEventMask;
      logic globalIrqMask;
   } mode_s;
endpackage : tci_pkg

// ===== src/time_critical_interrupt_flow.sv
// Acknowledge and dispatch of time-critical maskable interrupts
`timescale 1ns/1ps
`include "tci_defs.svh"

// Behaviour
// R1: Halted real-time mode: only debug-gated service
// R2: Not halted: requests go to standard flow
// R3: Requests latch pending flags until cleared
// R4: Acknowledge needs normal enable bit set
// R5: Acknowledge also needs debug enable bit
// R6: Acknowledge fetches vector and branches there
// R7: Decode-stage instructions finish, younger flushed
// R8: Branch clears the acknowledged pending flag
// R9: Branch saves mode and status context
// R10: Branch forces masks to one, access zero
// R11: Return instruction restores saved context
// R12: Not doubly enabled: request ignored
// R13: Return resumes at interrupted program point
// R14: Global mask does not gate this flow
module time_critical_interrupt_flow
   import tci_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Interrupt request lines from peripherals
   input wire logic [31:0] irqLines,
   // Core state
   input wire logic rtHalted,
   input wire logic [15:0] progCounter,
   input wire logic [15:0] statusWord,
   input wire logic retFromIrq,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   // Pipeline control and branch
   output logic flushYounger,
   output logic completeDecode,
   output logic branchValid,
   output logic [15:0] branchTarget,
   output logic [15:0] restoredStatus,
   output logic standardPending,
   // Mode bits and interrupt
   output mode_s modeBits,
   output logic irqOut
);

   // Three-stage synchroniser for the external request lines
   logic [31:0] sync1, sync2, sync3;
   // Pending flags, enables, debug enables
   logic [15:0] pending_flags_low, pending_flags_high;
   logic [15:0] irq_enable_low, irq_enable_high;
   logic [15:0] debug_irq_enable_low, debug_irq_enable_high;
   logic [15:0] vecBase; // Vector table base, entries four apart
   // Event status and mask: bit 0 acknowledge, bit 1 return
   logic [1:0] evtStatus, evtMask;
   // Flow state, drain countdown and the index being served;
   // one request is served at a time, so one index register does
   flow_e state;
   logic [1:0] drainCnt;
   logic [4:0] ackIdx;
   // Saved context
   logic [15:0] savedPc, savedStatus;
   mode_s savedMode;

   // Find lowest set bit, used for selection and its flag clear
   // Scanning down keeps the last hit, so the lowest index wins
   function automatic logic [4:0] lowest(input logic [31:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) r = i[4:0];
      end
      return r;
   endfunction : lowest

   // Decode
   wire [31:0] pend = {pending_flags_high, pending_flags_low};
   wire [31:0] en = {irq_enable_high, irq_enable_low};
   wire [31:0] den = {debug_irq_enable_high, debug_irq_enable_low};
   // Both enable sets gate; the global mask is deliberately not used
   // (the halted debug flow must reach its handlers regardless)
   wire [31:0] eligible = pend & en & den; // R4 R5 R14
   wire canAck = rtHalted && (|eligible) && (state == IDLE); // R1 R12
   // Agreed level of the last cycle, for rising-edge detection;
   // cleared to the idle level of the lines, so no false edge
   logic [31:0] prevReq;
   // New rising request edges once second and third stages agree;
   // a glitch seen by one stage only never sets a flag
   wire [31:0] newReq = sync2 & sync3 & ~prevReq; // R3
   // Write strobe seen by the write-one-to-clear decode
   wire wrAt = regWrite;
   wire [31:0] swClr = {
      (wrAt && regAddr == `OFS_PEND_HI) ? regWdata : 16'h0000,
      (wrAt && regAddr == `OFS_PEND_LO) ? regWdata : 16'h0000};
   wire [31:0] ackClr = (state == BRANCH) ? (32'h1 << ackIdx) : 32'h0;
   wire evtAck = (state == BRANCH);
   wire evtRet = (state == RESTORE);
   wire [1:0] evtSet = {evtRet, evtAck};
   // Set wins over clear so a simultaneous request is not lost
   wire [31:0] next_pend = (pend & ~swClr & ~ackClr) | newReq; // R3 R8

   // Request synchroniser; only the agreed stages are looked at
   // Nothing but sync2 reads sync1, which may go metastable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1 <= 32'h0;
         sync2 <= 32'h0;
         sync3 <= 32'h0;
         prevReq <= 32'h0;
      end else begin
         sync1 <= irqLines;
         sync2 <= sync1;
         sync3 <= sync2;
         prevReq <= sync2 & sync3;
      end
   end

   // Pending flags
   // Split into halves only to match the register map
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pending_flags_low <= 16'h0000;
         pending_flags_high <= 16'h0000;
      end else begin
         pending_flags_low <= next_pend[15:0]; // R3
         pending_flags_high <= next_pend[31:16];
      end
   end

   // Software-written registers
   // Writes to read-only or unmapped offsets are dropped
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_enable_low <= 16'h0000;
         irq_enable_high <= 16'h0000;
         debug_irq_enable_low <= 16'h0000;
         debug_irq_enable_high <= 16'h0000;
         vecBase <= `RST_VEC_BASE;
         evtMask <= 2'h0;
      end else if (regWrite) begin
         case (regAddr)
            `OFS_IEN_LO: irq_enable_low <= regWdata;
            `OFS_IEN_HI: irq_enable_high <= regWdata;
            `OFS_DIEN_LO: debug_irq_enable_low <= regWdata;
            `OFS_DIEN_HI: debug_irq_enable_high <= regWdata;
            `OFS_VEC_BASE: vecBase <= regWdata;
            `OFS_EVT_MASK: evtMask <= regWdata[1:0];
            default: ;
         endcase
      end
   end

   // Event status: write one to clear, hardware set wins
   // so an event in the clearing cycle is not lost
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         evtStatus <= 2'h0;
      end else begin
         evtStatus <= (evtStatus & ~((regWrite && regAddr == `OFS_EVT)
            ? regWdata[1:0] : 2'h0)) | evtSet;
      end
   end
   assign irqOut = |(evtStatus & evtMask);

   // Flow state machine
   // A new acknowledge waits for the return to IDLE
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= IDLE;
         drainCnt <= 2'h0;
         ackIdx <= 5'h00;
      end else begin
         case (state)
            IDLE: begin
               if (canAck) begin
                  ackIdx <= lowest(eligible);
                  drainCnt <= `DRAIN_CYCLES;
                  state <= DRAIN;
               end
            end
            DRAIN: begin // R7
               if (drainCnt == 2'h1) state <= BRANCH;
               drainCnt <= drainCnt - 2'h1;
            end
            BRANCH: state <= SERVICE; // R6
            SERVICE: if (retFromIrq) state <= RESTORE; // R11
            RESTORE: state <= IDLE;
            default: state <= IDLE;
         endcase
      end
   end

   // Context save on branch, mode forcing, restore on return
   // The forced entry values win over a mode write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         modeBits <= mode_s'(`RST_CTRL);
         savedMode <= mode_s'(3'h0);
         savedPc <= 16'h0000;
         savedStatus <= 16'h0000;
      end else if (state == BRANCH) begin
         savedMode <= modeBits; // R9
         savedPc <= progCounter;
         savedStatus <= statusWord;
         modeBits <= '{emuRegAccessEnable: 1'b0, debugEventMask: 1'b1,
            globalIrqMask: 1'b1}; // R10
      end else if (state == RESTORE) begin
         modeBits <= savedMode; // R11
      end else if (regWrite && regAddr == `OFS_CTRL) begin
         modeBits <= mode_s'(regWdata[2:0]);
      end
   end

   // Branch target and resume outputs from flops
   // The target holds until the next entry or resume
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         branchValid <= 1'b0;
         branchTarget <= 16'h0000;
         restoredStatus <= 16'h0000;
      end else begin
         branchValid <= (state == BRANCH) || (state == RESTORE);
         if (state == BRANCH) begin
            branchTarget <= vecBase + {9'h000, ackIdx, 2'h0}; // R6
         end else if (state == RESTORE) begin
            branchTarget <= savedPc; // R13
            restoredStatus <= savedStatus; // R11
         end
      end
   end

   // Pipeline control during the drain
   // Both strobes share the window; the core splits them per stage
   assign completeDecode = (state == DRAIN); // R7
   assign flushYounger = (state == DRAIN); // R7
   // Outside the halted state the standard flow takes requests
   assign standardPending = !rtHalted && (|(pend & en)); // R2

   // Read data one cycle after the strobe
   // Unmapped offsets read as zero
   wire [15:0] rdMux =
      (regAddr == `OFS_PEND_LO) ? pending_flags_low :
      (regAddr == `OFS_PEND_HI) ? pending_flags_high :
      (regAddr == `OFS_IEN_LO) ? irq_enable_low :
      (regAddr == `OFS_IEN_HI) ? irq_enable_high :
      (regAddr == `OFS_DIEN_LO) ? debug_irq_enable_low :
      (regAddr == `OFS_DIEN_HI) ? debug_irq_enable_high :
      (regAddr == `OFS_STATUS) ? {8'h00, ackIdx, state} :
      (regAddr == `OFS_CTRL) ? {13'h0000, modeBits} :
      (regAddr == `OFS_EVT) ? {14'h0000, evtStatus} :
      (regAddr == `OFS_EVT_MASK) ? {14'h0000, evtMask} :
      (regAddr == `OFS_VEC_BASE) ? vecBase : 16'h0000;
   always_ff @(posedge sys_clk) begin
      if (rst) regRdata <= 16'h0000;
      else regRdata <= regRead ? rdMux : 16'h0000;
   end

   // Checks
   // Flags, then acknowledge gating on the index actually chosen
   a_flag_latched: assert property (@(posedge sys_clk) disable iff (rst) // R3
      (newReq != 32'h0) |=> ((pend & $past(newReq)) == $past(newReq)))
      else $error("request not latched");
   a_ack_needs_en: assert property (@(posedge sys_clk) disable iff (rst) // R4
      $rose(state == DRAIN) |-> (|($past(en) & (32'h1 << ackIdx))))
      else $error("ack without enable");
   a_ack_needs_dbg: assert property (@(posedge sys_clk) disable iff (rst) // R5
      $rose(state == DRAIN) |-> (|($past(den) & (32'h1 << ackIdx))))
      else $error("ack without debug enable");
   a_only_halted: assert property (@(posedge sys_clk) disable iff (rst) // R1
      (state == IDLE && !rtHalted) |=> state != DRAIN)
      else $error("ack outside halt");
   a_drain_len: assert property (@(posedge sys_clk) disable iff (rst) // R7
      $rose(state == DRAIN) |-> flushYounger [*2] ##1 state == BRANCH)
      else $error("drain length wrong");
   a_modes_forced: assert property (@(posedge sys_clk) disable iff (rst) // R10
      state == BRANCH |=> modeBits == mode_s'(3'h3))
      else $error("mode not forced");
   a_flag_cleared: assert property (@(posedge sys_clk) disable iff (rst) // R8
      (state == BRANCH && !newReq[ackIdx]) |=> !pend[$past(ackIdx)])
      else $error("flag not cleared");
   a_resume_pc: assert property (@(posedge sys_clk) disable iff (rst) // R13
      state == RESTORE |=> branchValid && branchTarget == savedPc)
      else $error("resume address wrong");
   a_ignore_unen: assert property (@(posedge sys_clk) disable iff (rst) // R12
      (state == IDLE && eligible == 32'h0) |=> state == IDLE)
      else $error("unenabled request taken");
   // Entry side effects and the one-cycle branch pulse
   a_vector_target: assert property (@(posedge sys_clk) disable iff (rst) // R6
      state == BRANCH |=>
         branchTarget == $past(vecBase) + {9'h000, ackIdx, 2'h0})
      else $error("vector target wrong");
   a_context_saved: assert property (@(posedge sys_clk) disable iff (rst) // R9
      state == BRANCH |=> savedPc == $past(progCounter)
         && savedStatus == $past(statusWord) && savedMode == $past(modeBits))
      else $error("context not saved");
   a_branch_pulse: assert property (@(posedge sys_clk) disable iff (rst) // R6
      branchValid |=> !branchValid)
      else $error("branch pulse too long");

endmodule : time_critical_interrupt_flow

// ===== testbench/irq_source_model.sv
// Peripheral request lines and return strobe seen by the block
`timescale 1ns/1ps
module irq_source_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Commands from the bench
   input wire logic fire,
   input wire logic [4:0] fireIdx,
   input wire logic retReq,
   // Lines toward the block
   output logic [31:0] irqLines = 32'h0,
   output logic retFromIrq = 1'b0
);
   logic [2:0] hold = 3'h0; // Cycles the raised line still stands
   // Hold a line well past the 3-flop synchroniser, then drop it
   always @(posedge sys_clk) begin
      retFromIrq <= retReq && !rst;
      hold <= (hold != 3'h0) ? hold - 3'h1 : 3'h0;
      if (rst || hold == 3'h1) begin
         irqLines <= 32'h0;
      end
      if (fire && !rst) begin
         irqLines[fireIdx] <= 1'b1;
         hold <= 3'h6;
      end
   end
endmodule : irq_source_model

// ===== testbench/test_time_critical_interrupt_flow.sv
// Self-checking bench of the time-critical interrupt flow
`timescale 1ns/1ps
`include "tci_defs.svh"
module test_time_critical_interrupt_flow import tci_pkg::*;;
   logic sys_clk = 1'b0, rst = 1'b1, rtHalted = 1'b1;
   logic fire = 1'b0, retReq = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [4:0] fireIdx = 5'h00, idx;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0, progCounter = 16'h0;
   logic [15:0] statusWord = 16'h0, base, pc, sw, ctrl;
   logic [31:0] m;
   wire logic [31:0] irqLines;
   wire logic [15:0] regRdata, branchTarget, restoredStatus;
   wire logic retFromIrq, flushYounger, completeDecode, branchValid;
   wire logic standardPending, irqOut;
   wire mode_s modeBits;
   int numErrors = 0, numChecks = 0, cycles = 0, drains = 0;
   logic [15:0] readQ[$]; // Expected read data, oldest first
   logic [35:0] brQ[$]; // {resume, modes, status, target}
   logic rdPend = 1'b0;
   logic [35:0] e;
   always #12.5 sys_clk = ~sys_clk;
   irq_source_model u_src (.sys_clk(sys_clk), .rst(rst), .fire(fire),
      .fireIdx(fireIdx), .retReq(retReq), .irqLines(irqLines),
      .retFromIrq(retFromIrq));
   time_critical_interrupt_flow u_dut (.sys_clk(sys_clk), .rst(rst),
      .irqLines(irqLines), .rtHalted(rtHalted), .progCounter(progCounter),
      .statusWord(statusWord), .retFromIrq(retFromIrq), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .flushYounger(flushYounger),
      .completeDecode(completeDecode), .branchValid(branchValid),
      .branchTarget(branchTarget), .restoredStatus(restoredStatus),
      .standardPending(standardPending), .modeBits(modeBits),
      .irqOut(irqOut));
   // One compare for every kind of result
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // Register bus: one strobe cycle, then a release edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] d);
      readQ.push_back(d);
      @(posedge sys_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRead <= 1'b0;
   endtask : rd
   // Raise one request line through the source model
   task automatic raise(input logic [4:0] n);
      @(posedge sys_clk);
      fire <= 1'b1;
      fireIdx <= n;
      @(posedge sys_clk);
      fire <= 1'b0;
   endtask : raise
   // Bounded wait until every noted branch has been seen
   task automatic wait_q();
      repeat (40) if (brQ.size() != 0) @(posedge sys_clk);
      chk(16'(brQ.size()), 16'h0000);
   endtask : wait_q
   // Watcher: samples settled values, pops the oldest note per result
   always @(posedge sys_clk) begin
      cycles++;
      if (rdPend) chk(regRdata, readQ.pop_front());
      rdPend = regRead;
      if (flushYounger === 1'b1 && completeDecode === 1'b1) drains++;
      if (branchValid === 1'b1 && brQ.size() == 0) begin
         chk(16'h0001, 16'h0000);
      end else if (branchValid === 1'b1) begin
         e = brQ.pop_front();
         chk(branchTarget, e[15:0]);
         chk({13'h0, modeBits}, {13'h0, e[34:32]});
         if (e[35]) chk(restoredStatus, e[31:16]);
      end
      // Hang guard, far above the sequence; last so nothing follows it
      if (cycles == 6000) begin
         numErrors++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(33724));
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      chk({13'h0, modeBits}, 16'h0003);
      rd(`OFS_CTRL, {13'h0, `RST_CTRL});
      rd(`OFS_VEC_BASE, `RST_VEC_BASE);
      rd(4'hF, 16'h0000); // Unmapped reads as zero
      $display("test reset done");
      // Ack with global mask set, both halves and edge indices
      for (int i = 0; i < 4; i++) begin
         idx = (i == 0) ? 5'h00 : (i == 3) ? 5'h1F : 5'($urandom_range(31));
         m = 32'h1 << idx;
         ctrl = {13'h0, 1'b1, i[0], 1'b1};
         base = 16'($urandom) & 16'hFF00;
         pc = 16'($urandom);
         sw = 16'($urandom);
         wr(`OFS_CTRL, ctrl);
         wr(`OFS_IEN_LO, m[15:0]);
         wr(`OFS_IEN_HI, m[31:16]);
         wr(`OFS_DIEN_LO, m[15:0]);
         wr(`OFS_DIEN_HI, m[31:16]);
         wr(`OFS_VEC_BASE, base);
         wr(`OFS_EVT_MASK, 16'h0001);
         progCounter <= pc;
         statusWord <= sw;
         brQ.push_back({4'h3, 16'h0, base + {9'h0, idx, 2'h0}});
         raise(idx);
         wait_q();
         chk(16'(drains), 16'(2 * (i + 1)));
         rd(`OFS_PEND_LO, 16'h0000);
         rd(`OFS_PEND_HI, 16'h0000);
         chk({15'h0, irqOut}, 16'h0001);
         wr(`OFS_EVT, 16'h0001);
         @(posedge sys_clk);
         chk({15'h0, irqOut}, 16'h0000);
         brQ.push_back({1'b1, ctrl[2:0], sw, pc});
         @(posedge sys_clk);
         retReq <= 1'b1;
         @(posedge sys_clk);
         retReq <= 1'b0;
         wait_q();
         rd(`OFS_EVT, 16'h0002);
         wr(`OFS_EVT, 16'h0003);
      end
      $display("test acknowledge done");
      // Refusals: debug enable missing, then normal enable missing
      wr(`OFS_IEN_LO, 16'h0004);
      wr(`OFS_DIEN_LO, 16'h0000);
      raise(5'h02);
      repeat (12) @(posedge sys_clk);
      rd(`OFS_PEND_LO, 16'h0004);
      chk({15'h0, standardPending}, 16'h0000);
      rtHalted <= 1'b0;
      wr(`OFS_DIEN_LO, 16'h0004);
      chk({15'h0, standardPending}, 16'h0001);
      repeat (8) @(posedge sys_clk);
      wr(`OFS_PEND_LO, 16'h0004);
      rtHalted <= 1'b1;
      wr(`OFS_IEN_LO, 16'h0000);
      raise(5'h02);
      repeat (12) @(posedge sys_clk);
      rd(`OFS_PEND_LO, 16'h0004);
      chk(16'(drains), 16'h0008);
      $display("test refusal done");
      repeat (4) @(posedge sys_clk);
      report_and_stop();
   end
endmodule : test_time_critical_interrupt_flow
